// File: hdl/two_wire_slave_receiver.sv
// Two-wire slave receiver with a classic Wishbone register port
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "two_wire_slave_map.svh"

module two_wire_slave_receiver (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe_n,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  input  wire logic                      arb_lost,
  input  wire logic                      sleep_active,
  input  wire logic                      sleep_idle_mode,
  output logic                           wake_req,
  output logic                           irq_level
);
  import two_wire_slave_pkg::*;

  // Reset release
  logic        rst_meta_ff;
  logic        rst_sync_n_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  // Pin synchronisers: a level counts once stages two and three agree
  logic [2:0]  scl_sync_ff;
  logic [2:0]  sda_sync_ff;
  logic        scl_lvl_ff;
  logic        sda_lvl_ff;
  logic        scl_stable;
  logic        sda_stable;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_evt;
  logic        stop_evt;
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
  end

  assign scl_stable = (scl_sync_ff[1] == scl_sync_ff[2]);
  assign sda_stable = (sda_sync_ff[1] == sda_sync_ff[2]);
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      scl_lvl_ff <= 1'b1;
      sda_lvl_ff <= 1'b1;
    end else begin
      if (scl_stable) begin
        scl_lvl_ff <= scl_sync_ff[2];
      end
      if (sda_stable) begin
        sda_lvl_ff <= sda_sync_ff[2];
      end
    end
  end

  assign scl_rise  = scl_stable && scl_sync_ff[2] && !scl_lvl_ff;
  assign scl_fall  = scl_stable && !scl_sync_ff[2] && scl_lvl_ff;
  // SDA moving while SCL stays high marks a frame boundary
  assign start_evt = sda_stable && scl_lvl_ff && !sda_sync_ff[2]
                     && sda_lvl_ff;
  assign stop_evt  = sda_stable && scl_lvl_ff && sda_sync_ff[2]
                     && !sda_lvl_ff;
  // Registers
  logic        int_flag_ff;
  logic        ack_en_ff;
  logic        sta_ff;
  logic        sto_ff;
  logic        wcol_ff;
  logic        if_en_ff;
  logic        int_en_ff;
  byte_t       status_ff;
  byte_t       data_ff;
  byte_t       own_addr_ff;
  logic        arb_seen_ff;
  logic        wake_ff;
  logic        tx_mode_ff;
  // Link side
  link_state_t state_ff;
  byte_t       shift_ff;
  logic [3:0]  bit_cnt_ff;
  logic        gc_ff;
  logic        acked_ff;
  logic        sda_drv_ff;
  logic        scl_drv_ff;
  logic        evt_ff;
  byte_t       evt_status_ff;
  logic        evt_data_ff;
  logic        evt_addr_ff;
  logic        bus_wr;
  logic        bus_rd;
  logic        clk_off;
  logic        own_hit;
  logic        gc_hit;
  logic        flag_clear;
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                   && wb_sel_i[0];
  assign bus_rd  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign clk_off = sleep_active && !sleep_idle_mode;
  assign own_hit = (shift_ff[7:1] == own_addr_ff[7:1]);
  assign gc_hit  = (shift_ff[7:1] == 7'h00)
                   && own_addr_ff[`TWS_OA_GCE];
  assign flag_clear = bus_wr && (wb_adr_i == `TWS_OFF_CONTROL)
                      && wb_dat_i[`TWS_CTL_INT];
  // Bus slave: every access, mapped or not, is answered a cycle later
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      case (wb_adr_i)
        `TWS_OFF_CONTROL: wb_dat_o <= {24'h00_0000, int_flag_ff, ack_en_ff,
            sta_ff, sto_ff, wcol_ff, if_en_ff, 1'b0, int_en_ff};
        `TWS_OFF_STATUS: wb_dat_o <= {24'h00_0000,
            status_ff & `TWS_ST_CODE_MASK};
        `TWS_OFF_DATA: wb_dat_o <= {24'h00_0000, data_ff};
        `TWS_OFF_OWN_ADDR: wb_dat_o <= {24'h00_0000, own_addr_ff};
        `TWS_OFF_MODE: wb_dat_o <= {28'h000_0000, (state_ff != ST_IDLE),
            clk_off, wake_ff, tx_mode_ff};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  // Control bits written by software
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      ack_en_ff <= 1'b0;
      sta_ff    <= 1'b0;
      sto_ff    <= 1'b0;
      if_en_ff  <= 1'b0;
      int_en_ff <= 1'b0;
    end else if (bus_wr && (wb_adr_i == `TWS_OFF_CONTROL)) begin
      ack_en_ff <= wb_dat_i[`TWS_CTL_ACK];
      sta_ff    <= wb_dat_i[`TWS_CTL_STA];
      sto_ff    <= wb_dat_i[`TWS_CTL_STO];
      if_en_ff  <= wb_dat_i[`TWS_CTL_EN];
      int_en_ff <= wb_dat_i[`TWS_CTL_IE];
    end
  end
  // flag: hardware set wins over a same-cycle clear by writing one
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      int_flag_ff <= 1'b0;
    end else if (evt_ff) begin
      int_flag_ff <= 1'b1;
    end else if (flag_clear) begin
      int_flag_ff <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      status_ff <= `TWS_ST_NO_INFO;
    end else if (evt_ff) begin
      status_ff <= evt_status_ff;
    end else if (flag_clear) begin
      status_ff <= `TWS_ST_NO_INFO;
    end
  end
  // Data register; a write while the flag is low is a collision
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      data_ff <= `TWS_DATA_RST;
      wcol_ff <= 1'b0;
    end else begin
      if (evt_data_ff) begin
        data_ff <= shift_ff;
      end else if (bus_wr && (wb_adr_i == `TWS_OFF_DATA) && int_flag_ff) begin
        data_ff <= wb_dat_i[7:0];
      end
      if (bus_wr && (wb_adr_i == `TWS_OFF_DATA)) begin
        wcol_ff <= !int_flag_ff;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      own_addr_ff <= `TWS_OWN_ADDR_RST;
    end else if (bus_wr && (wb_adr_i == `TWS_OFF_OWN_ADDR)) begin
      own_addr_ff <= wb_dat_i[7:0];
    end
  end
  // lost arbitration remembered until the next address is taken
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      arb_seen_ff <= 1'b0;
    end else if (arb_lost) begin
      arb_seen_ff <= 1'b1;
    end else if (evt_addr_ff) begin
      arb_seen_ff <= 1'b0;
    end
  end
  // wake request stands until software clears the flag
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      wake_ff <= 1'b0;
    end else if (evt_addr_ff && clk_off) begin
      wake_ff <= 1'b1;
    end else if (flag_clear) begin
      wake_ff <= 1'b0;
    end
  end
  // transmit direction only recorded; that mode lives elsewhere
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      tx_mode_ff <= 1'b0;
    end else if (!if_en_ff || start_evt || stop_evt) begin
      tx_mode_ff <= 1'b0;
    end else if (state_ff == ST_ADDR && scl_fall
                 && bit_cnt_ff == `TWS_BITS_PER_BYTE && shift_ff[0]
                 && own_hit && ack_en_ff) begin
      tx_mode_ff <= 1'b1;
    end
  end
  // Link state machine
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      state_ff      <= ST_IDLE;
      shift_ff      <= 8'h00;
      bit_cnt_ff    <= 4'h0;
      gc_ff         <= 1'b0;
      acked_ff      <= 1'b0;
      sda_drv_ff    <= 1'b0;
      scl_drv_ff    <= 1'b0;
      evt_ff        <= 1'b0;
      evt_status_ff <= `TWS_ST_NO_INFO;
      evt_data_ff   <= 1'b0;
      evt_addr_ff   <= 1'b0;
    end else begin
      evt_ff      <= 1'b0;
      evt_data_ff <= 1'b0;
      evt_addr_ff <= 1'b0;
      // disabled interface stays off the bus
      if (!if_en_ff) begin
        state_ff   <= ST_IDLE;
        sda_drv_ff <= 1'b0;
        scl_drv_ff <= 1'b0;
      // every start is watched while enabled, even while not acknowledging
      end else if (start_evt) begin
        state_ff   <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_drv_ff <= 1'b0;
        scl_drv_ff <= 1'b0;
      end else if (stop_evt) begin
        state_ff   <= ST_IDLE;
        sda_drv_ff <= 1'b0;
        scl_drv_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_DATA: begin
            if (scl_rise && bit_cnt_ff != `TWS_BITS_PER_BYTE) begin
              shift_ff   <= {shift_ff[6:0], sda_lvl_ff};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall
                         && bit_cnt_ff == `TWS_BITS_PER_BYTE) begin
              if (state_ff == ST_ADDR) begin
                // ack only a write to us while enabled
                if (ack_en_ff && !shift_ff[0] && (own_hit || gc_hit)) begin
                  gc_ff      <= gc_hit && !own_hit;
                  sda_drv_ff <= 1'b1;
                  state_ff   <= ST_ADDR_ACK;
                end else begin
                  state_ff <= ST_SKIP;
                end
              end else begin
                acked_ff   <= ack_en_ff;
                sda_drv_ff <= ack_en_ff;
                state_ff   <= ST_DATA_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              sda_drv_ff  <= 1'b0;
              // stretch until the flag is cleared
              scl_drv_ff  <= 1'b1;
              acked_ff    <= 1'b1;
              state_ff    <= ST_HOLD;
              // flag and status after own or general call address
              evt_ff      <= 1'b1;
              evt_addr_ff <= 1'b1;
              evt_status_ff <= gc_ff
                  ? (arb_seen_ff ? `TWS_ST_ARB_GC : `TWS_ST_GC)
                  : (arb_seen_ff ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W);
            end
          end
          ST_DATA_ACK: begin
            if (scl_fall) begin
              sda_drv_ff  <= 1'b0;
              scl_drv_ff  <= 1'b1;
              state_ff    <= ST_HOLD;
              evt_ff      <= 1'b1;
              // the byte is kept only with the clock running
              evt_data_ff <= !clk_off;
              evt_status_ff <= gc_ff
                  ? (acked_ff ? `TWS_ST_GC_DATA : `TWS_ST_GC_NACK)
                  : (acked_ff ? `TWS_ST_OWN_DATA : `TWS_ST_OWN_NACK);
            end
          end
          ST_HOLD: begin
            // release once software has cleared the flag
            if (!evt_ff && !int_flag_ff) begin
              scl_drv_ff <= 1'b0;
              bit_cnt_ff <= 4'h0;
              state_ff   <= acked_ff ? ST_DATA : ST_SKIP;
            end
          end
          ST_IDLE, ST_SKIP: begin
            sda_drv_ff <= 1'b0;
            scl_drv_ff <= 1'b0;
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // Open drain: only ever pull low, enable low while pulling
  assign sda_out   = 1'b0;
  assign scl_out   = 1'b0;
  assign sda_oe_n  = !sda_drv_ff;
  assign scl_oe_n  = !scl_drv_ff;
  assign wake_req  = wake_ff;
  assign irq_level = int_flag_ff && int_en_ff;
endmodule // two_wire_slave_receiver

// File: common/two_wire_slave_map.svh
// Register offsets, field positions, reset values and status codes
`ifndef TWO_WIRE_SLAVE_MAP_SVH
`define TWO_WIRE_SLAVE_MAP_SVH

// Byte offsets on the register bus
`define TWS_OFF_CONTROL   8'h00
`define TWS_OFF_STATUS    8'h04
`define TWS_OFF_DATA      8'h08
`define TWS_OFF_OWN_ADDR  8'h0C
`define TWS_OFF_MODE      8'h10

// Control register fields
`define TWS_CTL_INT       7
`define TWS_CTL_ACK       6
`define TWS_CTL_STA       5
`define TWS_CTL_STO       4
`define TWS_CTL_WC        3
`define TWS_CTL_EN        2
`define TWS_CTL_IE        0

// Mode register fields (read only)
`define TWS_MODE_TX       0
`define TWS_MODE_WAKE     1
`define TWS_MODE_SLEEP    2
`define TWS_MODE_ADDRD    3

// Own address register fields
`define TWS_OA_GCE        0

// Reset values
`define TWS_CONTROL_RST   8'h00
`define TWS_OWN_ADDR_RST  8'h00
`define TWS_DATA_RST      8'h00

// Status codes, prescaler bits zero
`define TWS_ST_OWN_W      8'h60
`define TWS_ST_ARB_OWN_W  8'h68
`define TWS_ST_GC         8'h70
`define TWS_ST_ARB_GC     8'h78
`define TWS_ST_OWN_DATA   8'h80
`define TWS_ST_OWN_NACK   8'h88
`define TWS_ST_GC_DATA    8'h90
`define TWS_ST_GC_NACK    8'h98
`define TWS_ST_NO_INFO    8'hF8
`define TWS_ST_CODE_MASK  8'hF8

// Bits in a byte on the wire
`define TWS_BITS_PER_BYTE 4'h8

`endif

// File: common/two_wire_slave_pkg.sv
// Types shared by the two-wire slave receiver
package two_wire_slave_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_DATA     = 3'b011,
    ST_DATA_ACK = 3'b100,
    ST_HOLD     = 3'b101,
    ST_SKIP     = 3'b110
  } link_state_t;

  typedef logic [7:0] byte_t;

endpackage

// File: testbench/two_wire_slave_properties.sv
// Port checker for the two-wire slave receiver
`timescale 1ns/1ps
`include "two_wire_slave_map.svh"

module two_wire_slave_properties (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic       wb_ack_o,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_n,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       sleep_active,
  input wire logic       sleep_idle_mode,
  input wire logic       wake_req,
  input wire logic       irq_level
);
  logic [3:0] ctl_age_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Age of the last control write, saturating so old writes never match
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_age_ff <= 4'hF;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_sel_i[0] && wb_adr_i == `TWS_OFF_CONTROL) begin
      ctl_age_ff <= 4'h0;
    end else if (ctl_age_ff != 4'hF) begin
      ctl_age_ff <= ctl_age_ff + 4'h1;
    end
  end

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_bit;
    !sda_oe_n && scl_in;
  endsequence

  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_od_low;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  property p_ack_hold;
    s_ack_bit |=> !sda_oe_n;
  endproperty
  property p_stretch_low;
    $fell(scl_oe_n) |-> !$past(scl_in) && !$past(scl_in, 2);
  endproperty
  property p_scl_release;
    $rose(scl_oe_n) |-> ctl_age_ff <= 4'h3;
  endproperty
  property p_wake_src;
    $rose(wake_req) |-> sleep_active && !sleep_idle_mode;
  endproperty
  property p_wake_clear;
    $fell(wake_req) |-> ctl_age_ff <= 4'h3;
  endproperty
  property p_irq_clear;
    $fell(irq_level) |-> ctl_age_ff <= 4'h1;
  endproperty

  a_ack_next: assert property (p_ack_next)
    else $error("register access not acked next cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack longer than one cycle");
  a_od_low: assert property (p_od_low)
    else $error("open-drain output level not low");
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack bit released while clock high");
  a_stretch_low: assert property (p_stretch_low)
    else $error("clock stretch began while clock high");
  a_scl_release: assert property (p_scl_release)
    else $error("clock released without a control write");
  a_wake_src: assert property (p_wake_src)
    else $error("wake request outside deep sleep");
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake request dropped without a control write");
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt dropped without a control write");
endmodule // two_wire_slave_properties

bind two_wire_slave_receiver two_wire_slave_properties chk_u (
  .ref_clk        (ref_clk),
  .rst_n          (rst_n),
  .wb_cyc_i       (wb_cyc_i),
  .wb_stb_i       (wb_stb_i),
  .wb_we_i        (wb_we_i),
  .wb_adr_i       (wb_adr_i),
  .wb_sel_i       (wb_sel_i),
  .wb_ack_o       (wb_ack_o),
  .scl_in         (scl_in),
  .scl_out        (scl_out),
  .scl_oe_n       (scl_oe_n),
  .sda_out        (sda_out),
  .sda_oe_n       (sda_oe_n),
  .sleep_active   (sleep_active),
  .sleep_idle_mode(sleep_idle_mode),
  .wake_req       (wake_req),
  .irq_level      (irq_level)
);

// File: testbench/two_wire_bus_master.sv
// External two-wire bus master that writes bytes to the device
`timescale 1ns/1ps

module two_wire_bus_master (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_m,
  output logic      sda_m
);
  import two_wire_slave_pkg::*;

  // Released lines float high through the pull-ups
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // Waits out any clock stretch the device holds
  task automatic high();
    scl_m = 1'b1;
    wait (scl_w === 1'b1);
  endtask

  task automatic start();
    #80 sda_m = 1'b0;
    #80 scl_m = 1'b0;
    #80;
  endtask

  task automatic stop();
    #40 sda_m = 1'b0;
    #40 high();
    #80 sda_m = 1'b1;
    #80;
  endtask

  task automatic xfer(input byte_t b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40 sda_m = b[i];
      #40 high();
      #80 scl_m = 1'b0;
    end
    #40 sda_m = 1'b1;
    // Long low phase leaves the synchroniser time to place the ack
    #120 high();
    #40 ack = sda_w;
    #40 scl_m = 1'b0;
    #160;
  endtask
endmodule // two_wire_bus_master

// File: testbench/tb.sv
// Self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
`include "two_wire_slave_map.svh"

module tb;
  import two_wire_slave_pkg::*;

  // arb, control, own address, address byte, nack, status
  localparam logic [33:0] CASES [9] = '{
    {1'b0, 8'h05, 8'hA5, 8'hA4, 1'b1, 8'h00},
    {1'b0, 8'h45, 8'hA5, 8'hA4, 1'b0, 8'h60},
    {1'b0, 8'h45, 8'hA5, 8'h00, 1'b0, 8'h70},
    {1'b0, 8'h45, 8'hA4, 8'h00, 1'b1, 8'h00},
    {1'b0, 8'h45, 8'hA5, 8'h30, 1'b1, 8'h00},
    {1'b0, 8'h40, 8'hA5, 8'hA4, 1'b1, 8'h00},
    {1'b0, 8'h45, 8'hA5, 8'hA5, 1'b1, 8'h00},
    {1'b1, 8'h45, 8'hA5, 8'hA4, 1'b0, 8'h68},
    {1'b1, 8'h45, 8'hA5, 8'h00, 1'b0, 8'h78}
  };

  logic        ref_clk, rst_n, cyc, stb, we, arb, slp, slp_idle;
  logic        ack, scl_oe_n, sda_oe_n, wake, irq, scl_m, sda_m, abit;
  logic [3:0]  sel, sel_v;
  logic [7:0]  adr;
  logic [31:0] dat_i, dat_o;
  byte_t       q;
  int          bad_count, checks_done;
  wire         scl_w = scl_m & scl_oe_n;
  wire         sda_w = sda_m & sda_oe_n;

  two_wire_slave_receiver dut_u (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .wb_cyc_i       (cyc),
    .wb_stb_i       (stb),
    .wb_we_i        (we),
    .wb_adr_i       (adr),
    .wb_sel_i       (sel),
    .wb_dat_i       (dat_i),
    .wb_dat_o       (dat_o),
    .wb_ack_o       (ack),
    .scl_in         (scl_w),
    .scl_out        (),
    .scl_oe_n       (scl_oe_n),
    .sda_in         (sda_w),
    .sda_out        (),
    .sda_oe_n       (sda_oe_n),
    .arb_lost       (arb),
    .sleep_active   (slp),
    .sleep_idle_mode(slp_idle),
    .wake_req       (wake),
    .irq_level      (irq)
  );

  two_wire_bus_master m_u (
    .scl_w(scl_w),
    .sda_w(sda_w),
    .scl_m(scl_m),
    .sda_m(sda_m)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(string n, byte_t e, byte_t s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic bus(logic w, logic [7:0] a, byte_t d);
    int n;
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, dat_i} <= {2'b11, w, a, sel_v, 24'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_o[7:0];
    chk("wb_ack", 8'h01, {7'h0, ack});
    {cyc, stb} <= 2'b00;
  endtask

  task automatic rdc(logic [7:0] a, byte_t e);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, q);
  endtask

  // Selects wake_req when w is set, irq_level otherwise
  task automatic wait_hi(logic w);
    int n;
    n = 0;
    while ((w ? wake : irq) !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    chk(w ? "wake_req" : "irq_level", 8'h01, {7'h0, w ? wake : irq});
  endtask

  task automatic addr_case(logic [33:0] e);
    bus(1'b1, `TWS_OFF_OWN_ADDR, e[24:17]);
    bus(1'b1, `TWS_OFF_CONTROL, e[32:25]);
    if (e[33]) begin
      @(posedge ref_clk);
      arb <= 1'b1;
      @(posedge ref_clk);
      arb <= 1'b0;
    end
    m_u.start();
    m_u.xfer(e[16:9], abit);
    chk("addr_ack", {7'h0, e[8]}, {7'h0, abit});
    if (e[8]) begin
      repeat (20) @(posedge ref_clk);
      rdc(`TWS_OFF_CONTROL, e[32:25]);
      if (e[9]) begin
        rdc(`TWS_OFF_MODE, 8'h09);
      end
    end else begin
      wait_hi(1'b0);
      rdc(`TWS_OFF_STATUS, e[7:0]);
      bus(1'b1, `TWS_OFF_CONTROL, e[32:25] | 8'h80);
    end
    m_u.stop();
  endtask

  initial begin
    {rst_n, cyc, stb, we, arb, slp, slp_idle} = 7'h0;
    {adr, dat_i, sel} = 44'h0;
    sel_v = 4'hF;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdc(`TWS_OFF_CONTROL, `TWS_CONTROL_RST);
    rdc(`TWS_OFF_STATUS, `TWS_ST_NO_INFO);
    rdc(`TWS_OFF_DATA, `TWS_DATA_RST);
    bus(1'b1, 8'h20, 8'hFF);
    rdc(8'h20, 8'h00);
    bus(1'b1, `TWS_OFF_MODE, 8'hFF);
    rdc(`TWS_OFF_MODE, 8'h00);
    sel_v = 4'hE;
    bus(1'b1, `TWS_OFF_OWN_ADDR, 8'h77);
    sel_v = 4'hF;
    rdc(`TWS_OFF_OWN_ADDR, `TWS_OWN_ADDR_RST);
    for (int i = 0; i < 9; i++) addr_case(CASES[i]);
    m_u.start();
    m_u.xfer(8'hA4, abit);
    wait_hi(1'b0);
    bus(1'b1, `TWS_OFF_CONTROL, 8'hC5);
    m_u.xfer(8'h3C, abit);
    chk("data_ack", 8'h00, {7'h0, abit});
    wait_hi(1'b0);
    rdc(`TWS_OFF_STATUS, `TWS_ST_OWN_DATA);
    rdc(`TWS_OFF_DATA, 8'h3C);
    bus(1'b1, `TWS_OFF_CONTROL, 8'h85);
    m_u.xfer(8'hC3, abit);
    chk("data_nack", 8'h01, {7'h0, abit});
    wait_hi(1'b0);
    rdc(`TWS_OFF_STATUS, `TWS_ST_OWN_NACK);
    bus(1'b1, `TWS_OFF_CONTROL, 8'hC5);
    m_u.stop();
    @(posedge ref_clk);
    {slp, slp_idle} <= 2'b11;
    addr_case(CASES[1]);
    chk("idle_wake", 8'h00, {7'h0, wake});
    @(posedge ref_clk);
    slp_idle <= 1'b0;
    m_u.start();
    m_u.xfer(8'hA4, abit);
    chk("sleep_ack", 8'h00, {7'h0, abit});
    wait_hi(1'b1);
    rdc(`TWS_OFF_MODE, 8'h0E);
    @(posedge ref_clk);
    slp <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("scl_hold", 8'h00, {7'h0, scl_oe_n});
    wait_hi(1'b0);
    bus(1'b1, `TWS_OFF_CONTROL, 8'hC5);
    repeat (5) @(posedge ref_clk);
    chk("scl_free", 8'h01, {7'h0, scl_oe_n});
    chk("wake_end", 8'h00, {7'h0, wake});
    m_u.xfer(8'h5A, abit);
    wait_hi(1'b0);
    rdc(`TWS_OFF_STATUS, `TWS_ST_OWN_DATA);
    bus(1'b1, `TWS_OFF_CONTROL, 8'hC5);
    m_u.stop();
    wrap_up();
  end

  // Whole run needs well under 100 us
  initial begin
    #400_000;
    bad_count++;
    $display("[ERR] watchdog expected done seen hang");
    wrap_up();
  end
endmodule // tb
